// *** hw/dps_pkg.sv ***
package dps_pkg;
    // Command nibbles, top four bits of a frame
    localparam logic [3:0] CMD_NOP   = 4'h0;
    localparam logic [3:0] CMD_SAVE  = 4'h2;
    localparam logic [3:0] CMD_USER  = 4'h3;
    localparam logic [3:0] CMD_READ  = 4'h9;
    localparam logic [3:0] CMD_WRITE = 4'hb;
    localparam logic [3:0] CMD_SHL   = 4'hc;
    localparam logic [3:0] CMD_INC   = 4'he;

    // Address nibble values
    localparam logic [3:0] ADDR_CH1       = 4'h0;
    localparam logic [3:0] ADDR_CH2       = 4'h1;
    localparam logic [3:0] ADDR_USER_LOW  = 4'h2;

    // Frame layout
    localparam int         FRAME_BITS = 16;
    localparam logic [4:0] FRAME_LEN  = 5'h10;
    localparam logic [4:0] COUNT_MAX  = 5'h11;
    localparam int         CMD_MSB    = 15;
    localparam int         CMD_LSB    = 12;
    localparam int         ADDR_MSB   = 11;
    localparam int         ADDR_LSB   = 8;
    localparam int         DATA_MSB   = 7;

    // Storage
    localparam int         NV_DEPTH     = 16;
    localparam logic [7:0] WIPER_RESET  = 8'h80;
    localparam logic [7:0] NV_RESET     = 8'h80;
    localparam logic [7:0] WIPER_FULL   = 8'hff;
    localparam logic [15:0] WORD_RESET  = 16'h0000;

    // Link pins passed through the synchroniser
    localparam int         SYNC_WIDTH = 5;
    // Serial clock period used on the bench
    localparam int         LINK_PERIOD_NS = 125;
endpackage

// *** hw/dps_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module dps_pin_sync
    import dps_pkg::*;
(
    input  wire logic                  clock,   // System clock
    input  wire logic                  rst_n,   // Async reset, active low
    input  wire logic [SYNC_WIDTH-1:0] pinIn,   // Raw pins
    input  wire logic [SYNC_WIDTH-1:0] pinRst,  // Per-pin inversion mask XORed into the first stage
    output var  logic [SYNC_WIDTH-1:0] pinSync  // Pins after two flops
);
    logic [SYNC_WIDTH-1:0] stage1_reg;

    genvar i;
    generate
        for (i = 0; i < SYNC_WIDTH; i++) begin : g_bit
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    stage1_reg[i] <= 1'b1;
                    pinSync[i]    <= 1'b1;
                end else begin
                    stage1_reg[i] <= pinIn[i] ^ pinRst[i];
                    pinSync[i]    <= stage1_reg[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// *** hw/dps_command_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module dps_command_unit
    import dps_pkg::*;
(
    input  wire logic       clock,          // System clock, 125 MHz
    input  wire logic       rst_n,          // Async reset, active low
    input  wire logic       serialClock,    // Link clock from master
    input  wire logic       chipSelect_n,   // Frame select, active low
    input  wire logic       serialIn,       // Serial data from master
    input  wire logic       writeProtect_n, // Write protect, active low
    input  wire logic       presetStrobe,   // Preset reload strobe
    output var  logic       serialOut,      // Serial data to master
    output var  logic [7:0] wiperTerminal1, // Channel-one wiper setting
    output var  logic [7:0] wiperTerminal2, // Channel-two wiper setting
    output var  logic       activeState     // High while not idle
);
    logic [SYNC_WIDTH-1:0] pinSync;
    logic [SYNC_WIDTH-1:0] pinRst;
    logic                  sclkPrev_reg;
    logic                  csPrev_reg;
    logic                  presetPrev_reg;
    logic [15:0]           rxShift_reg;
    logic [15:0]           outShift_reg;
    logic [15:0]           lastWord_reg;
    logic [4:0]            bitCount_reg;
    logic [7:0]            nvStore_reg [NV_DEPTH];

    // Flip the idle-low pins so a stage reset to one reads as the pin at rest
    // and no false edge shows on any pin when reset lifts
    assign pinRst = 5'h07;

    dps_pin_sync u_sync (
        .clock   (clock),
        .rst_n   (rst_n),
        .pinIn   ({chipSelect_n, writeProtect_n, presetStrobe, serialIn, serialClock}),
        .pinRst  (pinRst),
        .pinSync (pinSync)
    );

    wire sclkS    = ~pinSync[0];
    wire sdiS     = ~pinSync[1];
    wire presetS  = ~pinSync[2];
    wire wpLow    = ~pinSync[3];
    wire csLow    = ~pinSync[4];

    wire sclkRise   = sclkS & ~sclkPrev_reg;
    wire sclkFall   = ~sclkS & sclkPrev_reg;
    wire csFall     = csLow & ~csPrev_reg;
    wire csRise     = ~csLow & csPrev_reg;
    wire presetRise = presetS & ~presetPrev_reg;

    wire [3:0] cmd  = rxShift_reg[CMD_MSB:CMD_LSB];
    wire [3:0] addr = rxShift_reg[ADDR_MSB:ADDR_LSB];
    wire [7:0] data = rxShift_reg[DATA_MSB:0];
    wire       exec = csRise & (bitCount_reg == FRAME_LEN);

    wire isWrite = exec & (cmd == CMD_WRITE);
    wire isInc   = exec & (cmd == CMD_INC);
    wire isShl   = exec & (cmd == CMD_SHL);
    wire isSave  = exec & (cmd == CMD_SAVE) & ~wpLow;
    wire isUser  = exec & (cmd == CMD_USER) & ~wpLow & (addr >= ADDR_USER_LOW);
    wire isRead  = exec & (cmd == CMD_READ);
    wire isNop   = exec & (cmd == CMD_NOP);

    wire [7:0] incVal1 = (wiperTerminal1 == WIPER_FULL) ? WIPER_FULL : wiperTerminal1 + 8'h01;
    wire [7:0] incVal2 = (wiperTerminal2 == WIPER_FULL) ? WIPER_FULL : wiperTerminal2 + 8'h01;
    wire [7:0] shlVal1 = wiperTerminal1[7] ? WIPER_FULL : {wiperTerminal1[6:0], 1'b0};
    wire [7:0] shlVal2 = wiperTerminal2[7] ? WIPER_FULL : {wiperTerminal2[6:0], 1'b0};

    wire [7:0] wiper1Next = presetRise                        ? nvStore_reg[0] :
                            (isWrite & (addr == ADDR_CH1))    ? data :
                            (isInc & (addr == ADDR_CH1))      ? incVal1 :
                            (isShl & (addr == ADDR_CH1))      ? shlVal1 : wiperTerminal1;
    wire [7:0] wiper2Next = presetRise                        ? nvStore_reg[1] :
                            (isWrite & (addr == ADDR_CH2))    ? data :
                            (isInc & (addr == ADDR_CH2))      ? incVal2 :
                            (isShl & (addr == ADDR_CH2))      ? shlVal2 : wiperTerminal2;

    wire [7:0]  saveVal   = (addr == ADDR_CH2) ? wiperTerminal2 : wiperTerminal1;
    wire [7:0]  readVal   = nvStore_reg[addr];
    wire [15:0] wordNext  = isRead ? {rxShift_reg[15:8], readVal} : rxShift_reg;
    wire [15:0] outNext   = csFall ? lastWord_reg :
                            (sclkFall & csLow) ? {outShift_reg[14:0], 1'b0} : outShift_reg;
    wire [4:0]  countNext = csFall ? 5'h00 :
                            (sclkRise & csLow & (bitCount_reg != COUNT_MAX)) ? bitCount_reg + 5'h01 :
                            bitCount_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sclkPrev_reg   <= 1'b0;
            csPrev_reg     <= 1'b0;
            presetPrev_reg <= 1'b0;
        end else begin
            sclkPrev_reg   <= sclkS;
            csPrev_reg     <= csLow;
            presetPrev_reg <= presetS;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rxShift_reg  <= WORD_RESET;
            bitCount_reg <= 5'h00;
        end else begin
            bitCount_reg <= countNext;
            if (sclkRise & csLow) begin
                rxShift_reg <= {rxShift_reg[14:0], sdiS};
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            outShift_reg <= WORD_RESET;
            serialOut    <= 1'b0;
            lastWord_reg <= WORD_RESET;
        end else begin
            outShift_reg <= outNext;
            serialOut    <= outNext[FRAME_BITS-1];
            if (exec) begin
                lastWord_reg <= wordNext;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wiperTerminal1 <= WIPER_RESET;
            wiperTerminal2 <= WIPER_RESET;
            activeState    <= 1'b0;
        end else begin
            wiperTerminal1 <= wiper1Next;
            wiperTerminal2 <= wiper2Next;
            if (isNop) begin
                activeState <= 1'b0;
            end else if (exec) begin
                activeState <= 1'b1;
            end
        end
    end

    genvar i;
    generate
        for (i = 0; i < NV_DEPTH; i++) begin : g_nv
            wire saveHit = isSave & (addr == 4'(i)) & (i < 2);
            wire userHit = isUser & (addr == 4'(i));
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    nvStore_reg[i] <= NV_RESET;
                end else if (saveHit) begin
                    nvStore_reg[i] <= saveVal;
                end else if (userHit) begin
                    nvStore_reg[i] <= data;
                end
            end
        end
    endgenerate

    wr_ch2_a: assert property (@(posedge clock) disable iff (!rst_n)
        (isWrite && addr == ADDR_CH2 && !presetRise) |=> wiperTerminal2 == $past(data))
        else $error("channel two direct write lost");
    wr_ch1_a: assert property (@(posedge clock) disable iff (!rst_n)
        (isWrite && addr == ADDR_CH1 && !presetRise) |=> wiperTerminal1 == $past(data))
        else $error("channel one direct write lost");
    echo_word_a: assert property (@(posedge clock) disable iff (!rst_n)
        csFall |=> outShift_reg == $past(lastWord_reg) ##1 serialOut == outShift_reg[15])
        else $error("previous word not echoed");
    inc_ch1_a: assert property (@(posedge clock) disable iff (!rst_n)
        (isInc && addr == ADDR_CH1 && !presetRise && wiperTerminal1 != WIPER_FULL)
        |=> wiperTerminal1 == $past(wiperTerminal1) + 8'h01)
        else $error("increment wrong");
    save_ch1_a: assert property (@(posedge clock) disable iff (!rst_n)
        (isSave && addr == ADDR_CH1) |=> nvStore_reg[0] == $past(wiperTerminal1))
        else $error("save to slot 0 wrong");
    shl_ch2_a: assert property (@(posedge clock) disable iff (!rst_n)
        (isShl && addr == ADDR_CH2 && !presetRise && !wiperTerminal2[7])
        |=> wiperTerminal2 == {$past(wiperTerminal2[6:0]), 1'b0})
        else $error("left shift wrong");
    user_slot_a: assert property (@(posedge clock) disable iff (!rst_n)
        (isUser && addr == 4'h3) |=> nvStore_reg[3] == $past(data))
        else $error("spare slot write wrong");
    read_back_a: assert property (@(posedge clock) disable iff (!rst_n)
        isRead |=> lastWord_reg[7:0] == $past(readVal))
        else $error("read fetch wrong");
    read_echo_a: assert property (@(posedge clock) disable iff (!rst_n)
        isRead |=> lastWord_reg[15:8] == $past(rxShift_reg[15:8]))
        else $error("read echo head wrong");
    nop_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
        isNop |=> !activeState)
        else $error("nop did not idle");
    wp_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        (exec && wpLow) |=> $stable(nvStore_reg[0]) && $stable(nvStore_reg[1]))
        else $error("protected slot changed");
    wp_spare_a: assert property (@(posedge clock) disable iff (!rst_n)
        (exec && wpLow) |=> $stable(nvStore_reg[2]) && $stable(nvStore_reg[3]))
        else $error("protected spare slot changed");
    preset_load_a: assert property (@(posedge clock) disable iff (!rst_n)
        presetRise |=> wiperTerminal1 == $past(nvStore_reg[0]) && wiperTerminal2 == $past(nvStore_reg[1]))
        else $error("preset reload wrong");
    short_frame_a: assert property (@(posedge clock) disable iff (!rst_n)
        (csRise && bitCount_reg != FRAME_LEN) |=> $stable(lastWord_reg))
        else $error("short frame executed");

    write_cov_c: cover property (@(posedge clock) disable iff (!rst_n) isWrite);
    read_cov_c: cover property (@(posedge clock) disable iff (!rst_n) isRead ##[1:1000] isNop);
    save_cov_c: cover property (@(posedge clock) disable iff (!rst_n) isSave);
    preset_cov_c: cover property (@(posedge clock) disable iff (!rst_n) presetRise);
    shift_cov_c: cover property (@(posedge clock) disable iff (!rst_n) isShl);
endmodule
`default_nettype wire

// *** dv/dps_serial_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module dps_serial_master (
    output var  logic serialClock,  // Link clock, idle low
    output var  logic chipSelect_n, // Frame select, active low
    output var  logic serialIn,     // Data to the block
    input  wire logic serialOut     // Data from the block
);
    localparam realtime HALF = 62.5;
    initial begin
        serialClock  = 1'b0;
        chipSelect_n = 1'b1;
        serialIn     = 1'b0;
    end
    // Data moves on the fall and the echo is taken on the rise
    task automatic frame(input logic [15:0] word, input int nBits, output logic [15:0] echo);
        echo = 16'h0000;
        serialIn = word[15];
        chipSelect_n = 1'b0;
        #HALF;
        for (int i = 0; i < nBits; i++) begin
            serialClock = 1'b1;
            echo = {echo[14:0], serialOut};
            #HALF;
            serialClock = 1'b0;
            serialIn = (i < 15) ? word[14-i] : ~serialIn;
            #HALF;
        end
        chipSelect_n = 1'b1;
        // Released line shows the inverse so a stale bit is never read as valid
        serialIn = ~serialIn;
        #(2*HALF);
    endtask
endmodule
`default_nettype wire

// *** dv/test_dps_command_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module test_dps_command_unit
    import dps_pkg::*;
;
    logic        clock;
    logic        rst_n;
    logic        serialClock;
    logic        chipSelect_n;
    logic        serialIn;
    logic        writeProtect_n;
    logic        presetStrobe;
    logic        serialOut;
    logic [7:0]  wiperTerminal1;
    logic [7:0]  wiperTerminal2;
    logic        activeState;
    logic [15:0] echo;
    logic [15:0] lastWord;
    int          miscompares;
    int          tests_run;

    dps_serial_master u_master (.serialClock(serialClock), .chipSelect_n(chipSelect_n),
        .serialIn(serialIn), .serialOut(serialOut));
    dps_command_unit u_dut (.clock(clock), .rst_n(rst_n), .serialClock(serialClock),
        .chipSelect_n(chipSelect_n), .serialIn(serialIn), .writeProtect_n(writeProtect_n),
        .presetStrobe(presetStrobe), .serialOut(serialOut), .wiperTerminal1(wiperTerminal1),
        .wiperTerminal2(wiperTerminal2), .activeState(activeState));

    always #4 clock = ~clock;

    task automatic close_out;
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic xfer(input logic [15:0] w, input logic [15:0] expEcho);
        u_master.frame(w, FRAME_BITS, echo);
        `CHK("echo", expEcho, echo)
        lastWord = w;
    endtask

    task automatic pins(input logic wp, input logic pr);
        @(posedge clock);
        writeProtect_n <= wp;
        presetStrobe   <= pr;
        repeat (8) @(posedge clock);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] v);
        xfer({CMD_READ, a, 8'h00}, lastWord);
        xfer(16'h0000, {CMD_READ, a, v});
        `CHK("idle", 1'b0, activeState)
    endtask

    task automatic t_direct;
        xfer(16'hb140, lastWord);
        `CHK("wiper2", 8'h40, wiperTerminal2)
        `CHK("active", 1'b1, activeState)
        xfer(16'hb080, 16'hb140);
        `CHK("wiper1", 8'h80, wiperTerminal1)
    endtask

    task automatic t_trim;
        xfer(16'hb040, lastWord);
        xfer(16'he000, 16'hb040);
        `CHK("inc1", 8'h41, wiperTerminal1)
        xfer(16'he0ff, lastWord);
        `CHK("inc2", 8'h42, wiperTerminal1)
        xfer(16'h2000, lastWord);
        xfer(16'hb100, lastWord);
        xfer(16'hb000, lastWord);
        pins(1'b1, 1'b1);
        pins(1'b1, 1'b0);
        `CHK("preset1", 8'h42, wiperTerminal1)
        `CHK("preset2", NV_RESET, wiperTerminal2)
    endtask

    task automatic t_short;
        u_master.frame(16'hb0aa, FRAME_BITS - 1, echo);
        `CHK("shortw", 8'h42, wiperTerminal1)
        xfer(16'hb121, lastWord);
    endtask

    task automatic t_shift;
        xfer(16'hc100, lastWord);
        `CHK("shl1", 8'h42, wiperTerminal2)
        xfer(16'hc1ff, lastWord);
        `CHK("shl2", 8'h84, wiperTerminal2)
    endtask

    task automatic t_user;
        xfer(16'h3255, lastWord);
        xfer(16'h33aa, lastWord);
        xfer(16'h3477, lastWord);
        rd(4'h2, 8'h55);
        rd(4'h3, 8'haa);
        rd(4'h4, 8'h77);
    endtask

    task automatic t_protect;
        pins(1'b0, 1'b0);
        xfer(16'hb0c3, lastWord);
        xfer(16'h2000, lastWord);
        xfer(16'h3211, lastWord);
        pins(1'b1, 1'b0);
        `CHK("wpw1", 8'hc3, wiperTerminal1)
        rd(4'h0, 8'h42);
        rd(4'h2, 8'h55);
    endtask

    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        writeProtect_n = 1'b1;
        presetStrobe = 1'b0;
        miscompares = 0;
        tests_run = 0;
        lastWord = WORD_RESET;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (8) @(posedge clock);
        t_direct();
        t_trim();
        t_short();
        t_shift();
        t_user();
        t_protect();
        close_out();
    end

    initial begin
        repeat (50000) @(posedge clock);
        miscompares++;
        close_out();
    end
endmodule
`default_nettype wire
